/* File: include/obt_defines.svh */
// register offsets, field positions and reset values of the registered transceiver
`ifndef OBT_DEFINES_SVH
`define OBT_DEFINES_SVH

`define OBT_ADDR_CTRL 8'h00
`define OBT_ADDR_STATUS 8'h04
`define OBT_ADDR_A_STORE 8'h08
`define OBT_ADDR_B_STORE 8'h0C
`define OBT_ADDR_A_LOG 8'h10

`define OBT_CTRL_SOFT_A 0
`define OBT_CTRL_SOFT_B 1

`define OBT_STAT_LOG_VALID 0
`define OBT_STAT_LOG_FULL 1
`define OBT_STAT_LOG_OVF 2
`define OBT_STAT_A_DRIVE 3
`define OBT_STAT_B_DRIVE 4

`define OBT_LOG_DEPTH 2
`define OBT_SYNC_RESET 22'h100000

`endif

/* File: include/obt_pkg.sv */
// types shared by the registered transceiver
package obt_pkg;
    typedef struct packed {
        logic a_to_b_drive_enable;
        logic b_to_a_drive_enable_n;
        logic a_capture_clock;
        logic b_capture_clock;
        logic b_output_source_select;
        logic a_output_source_select;
    } obt_ctrl_t;

    typedef struct packed {
        obt_ctrl_t ctrl;
        logic [7:0] a;
        logic [7:0] b;
    } obt_pins_t;
endpackage

/* File: hw/obt_transceiver.sv */
// octal registered bus transceiver with a wishbone status and capture-log port
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "obt_defines.svh"

module obt_transceiver
    import obt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire obt_ctrl_t ctrl,
    input wire logic [7:0] a_in,
    output logic [7:0] a_out,
    output logic a_oe_n,
    input wire logic [7:0] b_in,
    output logic [7:0] b_out,
    output logic b_oe_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // every pin, capture clocks included, is sampled on ref_clk; data must be
    // steady for a few ref_clk cycles around a capture edge
    obt_pins_t pin_s1;
    obt_pins_t pin_s2;
    logic a_clk_d;
    logic b_clk_d;
    logic [7:0] a_store;
    logic [7:0] b_store;
    logic soft_a;
    logic soft_b;
    logic log_ovf;
    logic [7:0] log_mem [0:`OBT_LOG_DEPTH-1];
    logic log_wp;
    logic log_rp;
    logic [1:0] log_cnt;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= `OBT_SYNC_RESET;
            pin_s2 <= `OBT_SYNC_RESET;
        end else begin
            pin_s1 <= {ctrl, a_in, b_in};
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_clk_d <= 1'b0;
            b_clk_d <= 1'b0;
        end else begin
            a_clk_d <= pin_s2.ctrl.a_capture_clock;
            b_clk_d <= pin_s2.ctrl.b_capture_clock;
        end
    end

    wire logic a_rise = (pin_s2.ctrl.a_capture_clock && !a_clk_d) || soft_a;
    wire logic b_rise = (pin_s2.ctrl.b_capture_clock && !b_clk_d) || soft_b;
    wire logic b_drive = pin_s2.ctrl.a_to_b_drive_enable;
    wire logic a_drive = !pin_s2.ctrl.b_to_a_drive_enable_n;
    wire logic b_live = b_drive && !pin_s2.ctrl.b_output_source_select;
    wire logic a_live = a_drive && !pin_s2.ctrl.a_output_source_select;

    // no reset on purpose: contents are whatever the first capture brings
    always_ff @(posedge ref_clk) begin
        if (a_rise) begin
            a_store <= a_live ? pin_s2.b : pin_s2.a;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (b_rise) begin
            b_store <= b_live ? pin_s2.a : pin_s2.b;
        end
    end

    // with simultaneous edges both registers load in the same cycle from the synchronized
    // pins, never from each other, so the order of the two edges does not matter

    // registered mux: the port changes once per cycle, never mid-decode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            b_out <= 8'h00;
            b_oe_n <= 1'b1;
            a_out <= 8'h00;
            a_oe_n <= 1'b1;
        end else begin
            b_oe_n <= !b_drive;
            a_oe_n <= !a_drive;
            b_out <= pin_s2.ctrl.b_output_source_select ? a_store : pin_s2.a;
            a_out <= pin_s2.ctrl.a_output_source_select ? b_store : pin_s2.b;
        end
    end
    // both live and both enabled: each port echoes the other, the wire holds

    // two-entry log of A-side captures; a full log refuses and flags overflow
    wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic log_in_ready = (log_cnt != 2'(`OBT_LOG_DEPTH));
    wire logic log_out_valid = (log_cnt != 2'h0);
    wire logic log_push = a_rise && log_in_ready;
    wire logic log_pop = wb_req && !wb_we_i && (wb_adr_i == `OBT_ADDR_A_LOG) && log_out_valid;
    wire logic ovf_clr = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `OBT_ADDR_STATUS)
        && wb_dat_i[`OBT_STAT_LOG_OVF];

    always_ff @(posedge ref_clk) begin
        if (log_push) begin
            log_mem[log_wp] <= a_live ? pin_s2.b : pin_s2.a;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            log_wp <= 1'b0;
            log_rp <= 1'b0;
            log_cnt <= 2'h0;
        end else begin
            if (log_push) begin
                log_wp <= !log_wp;
            end
            if (log_pop) begin
                log_rp <= !log_rp;
            end
            log_cnt <= log_cnt + 2'(log_push) - 2'(log_pop);
        end
    end

    // a new overflow in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            log_ovf <= 1'b0;
        end else if (a_rise && !log_in_ready) begin
            log_ovf <= 1'b1;
        end else if (ovf_clr) begin
            log_ovf <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            soft_a <= 1'b0;
            soft_b <= 1'b0;
        end else begin
            soft_a <= wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `OBT_ADDR_CTRL)
                && wb_dat_i[`OBT_CTRL_SOFT_A];
            soft_b <= wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `OBT_ADDR_CTRL)
                && wb_dat_i[`OBT_CTRL_SOFT_B];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `OBT_ADDR_STATUS: begin
                        wb_dat_o[`OBT_STAT_LOG_VALID] <= log_out_valid;
                        wb_dat_o[`OBT_STAT_LOG_FULL] <= !log_in_ready;
                        wb_dat_o[`OBT_STAT_LOG_OVF] <= log_ovf;
                        wb_dat_o[`OBT_STAT_A_DRIVE] <= a_drive;
                        wb_dat_o[`OBT_STAT_B_DRIVE] <= b_drive;
                    end
                    `OBT_ADDR_A_STORE: wb_dat_o[7:0] <= a_store;
                    `OBT_ADDR_B_STORE: wb_dat_o[7:0] <= b_store;
                    `OBT_ADDR_A_LOG: wb_dat_o[7:0] <= log_out_valid ? log_mem[log_rp] : 8'h00;
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // assertion helpers only: the stores carry no reset, so hold checks wait for a first load
    logic a_loaded;
    logic b_loaded;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_loaded <= 1'b0;
            b_loaded <= 1'b0;
        end else begin
            if (a_rise) begin
                a_loaded <= 1'b1;
            end
            if (b_rise) begin
                b_loaded <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_b_enable: assert property (1'b1 |=> b_oe_n == !$past(b_drive))
        else $error("port B drive does not follow its enable");
    a_a_enable: assert property (1'b1 |=> a_oe_n == !$past(a_drive))
        else $error("port A drive does not follow its enable");
    a_b_live_path: assert property (b_live |=> b_out == $past(pin_s2.a))
        else $error("B not driven with live A");
    a_b_stored_path: assert property (b_drive && !b_live |=> b_out == $past(a_store))
        else $error("B not driven from A register");
    a_a_live_path: assert property (a_live |=> a_out == $past(pin_s2.b))
        else $error("A not driven with live B");
    a_a_stored_path: assert property (a_drive && !a_live |=> a_out == $past(b_store))
        else $error("A not driven from B register");
    a_a_capture_load: assert property (a_rise && !a_live |=> a_store == $past(pin_s2.a))
        else $error("A register missed a capture");
    a_b_capture_load: assert property (b_rise && !b_live |=> b_store == $past(pin_s2.b))
        else $error("B register missed a capture");
    a_b_takes_a: assert property (b_rise && b_live |=> b_store == $past(pin_s2.a))
        else $error("B register did not take live A");
    a_a_takes_b: assert property (a_rise && a_live |=> a_store == $past(pin_s2.b))
        else $error("A register did not take live B");
    a_wb_ack_once: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle");

    // a select change moves the port straight from one source to the other
    a_b_no_glitch: assert property (1'b1 |=> b_out == $past(pin_s2.a)
        || b_out == $past(a_store))
        else $error("B output took neither live nor stored data");
    a_a_no_glitch: assert property (1'b1 |=> a_out == $past(pin_s2.b)
        || a_out == $past(b_store))
        else $error("A output took neither live nor stored data");
    a_iso_both: assert property (!a_drive && !b_drive |=> a_oe_n && b_oe_n)
        else $error("a port is driven while isolated");

    // storage holds between captures
    a_a_store_hold: assert property (a_loaded && !a_rise |=> a_store == $past(a_store))
        else $error("A register changed without a capture");
    a_b_store_hold: assert property (b_loaded && !b_rise |=> b_store == $past(b_store))
        else $error("B register changed without a capture");

    // register bus and capture log
    a_ack_gap: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack held for two cycles");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    a_status_drive: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_STATUS
        |=> wb_dat_o[`OBT_STAT_A_DRIVE] == $past(a_drive) && wb_dat_o[`OBT_STAT_B_DRIVE] == $past(b_drive))
        else $error("status drive bits wrong");
    a_log_full_flag: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_STATUS
        |=> wb_dat_o[`OBT_STAT_LOG_FULL] == ($past(log_cnt) == 2'(`OBT_LOG_DEPTH)))
        else $error("status full bit wrong");
    a_log_valid_flag: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_STATUS
        |=> wb_dat_o[`OBT_STAT_LOG_VALID] == ($past(log_cnt) != 2'h0))
        else $error("status valid bit wrong");
    a_ctrl_reads_zero: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_CTRL |=> wb_dat_o == 32'h00000000)
        else $error("control register read not zero");
    a_unmapped_read: assert property (wb_req && !wb_we_i && wb_adr_i > `OBT_ADDR_A_LOG
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read returned data");
    a_a_store_read: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_A_STORE && a_loaded
        |=> wb_dat_o[7:0] == $past(a_store))
        else $error("A register read wrong");
    a_b_store_read: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_B_STORE && b_loaded
        |=> wb_dat_o[7:0] == $past(b_store))
        else $error("B register read wrong");
    a_empty_log_read: assert property (wb_req && !wb_we_i && wb_adr_i == `OBT_ADDR_A_LOG && !log_out_valid
        |=> wb_dat_o == 32'h00000000)
        else $error("empty log read not zero");
    a_log_bound: assert property (log_cnt <= 2'(`OBT_LOG_DEPTH))
        else $error("log count beyond its depth");
    a_log_push_count: assert property (log_push && !log_pop |=> log_cnt == $past(log_cnt) + 2'h1)
        else $error("log count missed a push");
    a_log_pop_count: assert property (log_pop && !log_push |=> log_cnt == $past(log_cnt) - 2'h1)
        else $error("log count missed a pop");
    a_ovf_set: assert property (a_rise && !log_in_ready |=> log_ovf)
        else $error("overflow not flagged on a full log");
    a_ovf_clear: assert property (ovf_clr && log_in_ready |=> !log_ovf)
        else $error("overflow not cleared");
    a_ovf_sticky: assert property (log_ovf && !ovf_clr |=> log_ovf)
        else $error("overflow dropped without a clear");
    a_soft_pulse: assert property (soft_a || soft_b |=> !soft_a && !soft_b)
        else $error("software capture longer than one cycle");

    c_both_stored: cover property (b_drive && a_drive && !b_live && !a_live);
    c_loopback: cover property (b_live && a_live);
    c_log_full: cover property (!log_in_ready && a_rise);
    c_live_to_stored: cover property (b_live ##1 b_drive && !b_live);
    c_log_drain: cover property (log_pop && log_cnt == 2'h1);
endmodule // obt_transceiver
`default_nettype wire

/* File: testbench/obt_bus_model.sv */
// far-side logic on the A and B buses
`timescale 1ns/1ns
`default_nettype none
module obt_bus_model (
    input wire logic ref_clk,
    input wire logic [7:0] a_out,
    input wire logic a_oe_n,
    input wire logic [7:0] b_out,
    input wire logic b_oe_n,
    input wire logic ext_en,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    output logic [7:0] a_in,
    output logic [7:0] b_in
);
    logic [7:0] a_last = 8'h00;
    logic [7:0] b_last = 8'h00;
    // far side drives only where the device does not, so no contention
    // a released bus has no pull: flip the last value so stale data is caught
    assign a_in = !a_oe_n ? a_out : ext_en ? ext_a : ~a_last;
    assign b_in = !b_oe_n ? b_out : ext_en ? ext_b : ~b_last;
    always_ff @(posedge ref_clk) begin
        a_last <= a_in;
        b_last <= b_in;
    end
endmodule // obt_bus_model
`default_nettype wire

/* File: testbench/obt_transceiver_test.sv */
// self-checking bench for the registered transceiver
`timescale 1ns/1ns
`default_nettype none
`include "obt_defines.svh"
module obt_transceiver_test;
    import obt_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    obt_ctrl_t c = 6'h10;
    logic [7:0] a_in, a_out, b_in, b_out;
    logic [7:0] ext_a = 8'h5A;
    logic [7:0] ext_b = 8'hC3;
    logic a_oe_n, b_oe_n, ack;
    logic ext_en = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd;
    int errors = 0;
    int samples_checked = 0;
    obt_transceiver dut (.ref_clk(ref_clk), .rstn(rstn), .ctrl(c), .a_in(a_in), .a_out(a_out),
        .a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    obt_bus_model far (.ref_clk(ref_clk), .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
        .b_oe_n(b_oe_n), .ext_en(ext_en), .ext_a(ext_a), .ext_b(ext_b), .a_in(a_in),
        .b_in(b_in));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one classic cycle; waits on ack under a bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        @(posedge ref_clk);
    endtask
    // capture pulse held past the two-stage sync on both edges; one clock per call keeps
    // the two capture edges apart whatever the selects are
    task automatic cap(input logic side_b);
        if (side_b)
            c.b_capture_clock <= 1'b1;
        else
            c.a_capture_clock <= 1'b1;
        wait_n(4);
        c.a_capture_clock <= 1'b0;
        c.b_capture_clock <= 1'b0;
        wait_n(4);
    endtask
    initial begin
        wait_n(16);
        rstn <= 1'b1;
        wait_n(4);
        check(32'({a_oe_n, b_oe_n}), 32'h3);
        wb(1'b1, 8'h20, 32'hFF);
        wb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        c.a_to_b_drive_enable <= 1'b1;
        wait_n(4);
        check(32'({a_oe_n, b_oe_n, b_out}), 32'h25A);
        cap(1'b0);
        wb(1'b0, `OBT_ADDR_A_STORE, 32'h0);
        check(rd, 32'h5A);
        ext_a <= 8'h96;
        c.b_output_source_select <= 1'b1;
        wait_n(4);
        check(32'(b_out), 32'h5A);
        c.b_output_source_select <= 1'b0;
        wait_n(4);
        check(32'(b_out), 32'h96);
        cap(1'b1);
        wb(1'b0, `OBT_ADDR_B_STORE, 32'h0);
        check(rd, 32'h96);
        c <= 6'h00;
        ext_b <= 8'h3C;
        wait_n(8);
        check(32'({a_oe_n, b_oe_n, a_out}), 32'h13C);
        cap(1'b0);
        wb(1'b0, `OBT_ADDR_A_STORE, 32'h0);
        check(rd, 32'h3C);
        ext_b <= 8'h81;
        wait_n(4);
        cap(1'b1);
        c.a_output_source_select <= 1'b1;
        ext_b <= 8'h42;
        wait_n(4);
        check(32'(a_out), 32'h81);
        c <= 6'h23;
        wait_n(4);
        check(32'({a_oe_n, b_oe_n, a_out, b_out}), 32'h813C);
        wb(1'b0, `OBT_ADDR_STATUS, 32'h0);
        check(rd & 32'h18, 32'h18);
        // the two A captures so far fill the log; a software capture overflows it
        check(rd & 32'h7, 32'h3);
        wb(1'b1, `OBT_ADDR_CTRL, 32'h1);
        wb(1'b0, `OBT_ADDR_STATUS, 32'h0);
        check(rd & 32'h7, 32'h7);
        wb(1'b0, `OBT_ADDR_A_STORE, 32'h0);
        check(rd, 32'h81);
        wb(1'b0, `OBT_ADDR_A_LOG, 32'h0);
        check(rd, 32'h5A);
        wb(1'b0, `OBT_ADDR_A_LOG, 32'h0);
        check(rd, 32'h3C);
        wb(1'b0, `OBT_ADDR_A_LOG, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `OBT_ADDR_STATUS, 32'h4);
        wb(1'b0, `OBT_ADDR_STATUS, 32'h0);
        check(rd & 32'h7, 32'h0);
        c <= 6'h20;
        ext_en <= 1'b0;
        wait_n(8);
        check(32'({a_oe_n, b_oe_n, a_out, b_out}), 32'h8181);
        finish_test();
    end
endmodule // obt_transceiver_test
`default_nettype wire
